//--- design/wwd_top.v
// windowed watchdog: keyed restart, write-once mode, clear-on-read fault status
`timescale 1ns/10ps
`default_nettype none
`include "wwd_defs.vh"

module wwd_top #(
    parameter SLOW_DIVIDE = 1526,
    parameter SLOW_WIDTH  = 11
) (
    // clock and reset
    input  wire        MCLK_I,
    input  wire        SYS_RST_I,
    // wishbone slave
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [3:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O,
    // processor state
    input  wire        DEBUG_STATE_I,
    input  wire        IDLE_STATE_I,
    // fault outputs
    output reg         FAULT_IRQ_O,
    output reg         WDT_FAULT_O,
    output reg         PROC_ONLY_RESET_O,
    // current count for observation
    output reg  [11:0] COUNT_O
);

    localparam CW = `WWD_COUNTER_WIDTH;

    reg  [31:0]   mode_config_once;
    reg           mode_locked;
    reg           underflow_flag;
    reg           window_error_flag;
    reg  [CW-1:0] count;
    wire          slow_tick;
    wire          prescale_tick;

    // decoded mode fields
    wire [CW-1:0] reload_value          = mode_config_once[`WWD_RELOAD_MSB:`WWD_RELOAD_LSB];
    wire [CW-1:0] window_delta          = mode_config_once[`WWD_DELTA_MSB:`WWD_DELTA_LSB];
    wire          fault_irq_enable      = mode_config_once[`WWD_FAULT_IRQ_EN_BIT];
    wire          reset_on_fault_enable = mode_config_once[`WWD_RESET_EN_BIT];
    wire          processor_only_reset  = mode_config_once[`WWD_PROC_ONLY_BIT];
    wire          counter_disable       = mode_config_once[`WWD_DISABLE_BIT];
    wire          debug_halt            = mode_config_once[`WWD_DEBUG_HALT_BIT];
    wire          idle_halt             = mode_config_once[`WWD_IDLE_HALT_BIT];

    // bus strobes; classic cycle answered one clock after the request
    wire bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire wr      = bus_req && WB_WE_I;
    wire rd      = bus_req && !WB_WE_I;
    wire hit_cr  = WB_ADR_I == `WWD_OFS_RESTART_CONTROL;
    wire hit_mr  = WB_ADR_I == `WWD_OFS_MODE_CONFIG_ONCE;
    wire hit_sr  = WB_ADR_I == `WWD_OFS_FAULT_STATUS;

    // key must match in full; key lane must be enabled too
    wire key_ok  = WB_SEL_I[3] && (WB_DAT_I[`WWD_KEY_MSB:`WWD_KEY_LSB] == `WWD_WRITE_KEY_VALUE);
    wire restart = wr && hit_cr && key_ok && WB_DAT_I[`WWD_RESTART_BIT];
    // write-once; all lanes are taken together so a partial write still locks
    wire mode_wr = wr && hit_mr && !mode_locked;
    wire sr_read = rd && hit_sr;

    // window check: counter above delta means restart came too early
    wire early   = restart && (count > window_delta);

    // counting allowed unless disabled or halted
    wire run_en  = !counter_disable && !(debug_halt && DEBUG_STATE_I) && !(idle_halt && IDLE_STATE_I);
    wire reload  = restart || mode_wr;
    wire underflow = run_en && prescale_tick && !reload && (count == {CW{1'b0}});

    // slow clock enable
    wwd_slow_tick #(
        .DIVIDE (SLOW_DIVIDE),
        .WIDTH  (SLOW_WIDTH)
    ) u_slow (
        .clk_i  (MCLK_I),
        .rst_i  (SYS_RST_I),
        .tick_o (slow_tick)
    );

    // divide-by-128 prescaler, cleared on each reload
    wwd_tick_div #(
        .DIVIDE   (`WWD_PRESCALE_DIV),
        .WIDTH    (7)
    ) u_presc (
        .clk_i    (MCLK_I),
        .rst_i    (SYS_RST_I),
        .clear_i  (reload),
        .enable_i (run_en),
        .step_i   (slow_tick),
        .tick_o   (prescale_tick)
    );

    // mode register: reset values, one write only until reset
    always @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            mode_config_once <= `WWD_MODE_RESET;
            mode_locked      <= 1'b0;
        end else if (mode_wr) begin
            mode_config_once <= WB_DAT_I & `WWD_MODE_MASK;
            mode_locked      <= 1'b1;
        end
    end

    // down counter; new mode parameters take effect on the same reload
    always @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            count <= {CW{1'b1}};
        end else if (mode_wr) begin
            count <= WB_DAT_I[`WWD_RELOAD_MSB:`WWD_RELOAD_LSB];
        end else if (restart) begin
            count <= reload_value;
        end else if (underflow) begin
            count <= reload_value;
        end else if (run_en && prescale_tick) begin
            count <= count - 1'b1;
        end
    end

    // sticky flags; a new event in the read cycle wins over the clear
    always @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            underflow_flag    <= 1'b0;
            window_error_flag <= 1'b0;
        end else begin
            underflow_flag    <= underflow || (underflow_flag && !sr_read);
            window_error_flag <= early || (window_error_flag && !sr_read);
        end
    end

    // fault, interrupt and reset routing follow the flags and mode
    always @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            FAULT_IRQ_O       <= 1'b0;
            WDT_FAULT_O       <= 1'b0;
            PROC_ONLY_RESET_O <= 1'b0;
        end else begin
            if (sr_read && !underflow && !early) begin
                FAULT_IRQ_O <= 1'b0;
                WDT_FAULT_O <= 1'b0;
            end else begin
                if ((underflow || early) && fault_irq_enable)
                    FAULT_IRQ_O <= 1'b1;
                if ((underflow && reset_on_fault_enable) || early)
                    WDT_FAULT_O <= 1'b1;
            end
            PROC_ONLY_RESET_O <= processor_only_reset;
        end
    end

    // wishbone answer; unmapped reads give zero, writes ignored
    always @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= bus_req;
            if (rd && hit_mr)
                WB_DAT_O <= mode_config_once;
            else if (sr_read)
                WB_DAT_O <= {30'h00000000, window_error_flag, underflow_flag};
            else
                WB_DAT_O <= 32'h00000000;
        end
    end

    // count shown for observation
    always @(posedge MCLK_I) begin
        if (SYS_RST_I)
            COUNT_O <= 12'hfff;
        else
            COUNT_O <= count;
    end

endmodule // wwd_top
`default_nettype wire

//--- design/wwd_defs.vh
// register map, field positions, reset values and timing counts of the windowed watchdog
`ifndef WWD_DEFS_VH
`define WWD_DEFS_VH

// register byte offsets (all four address bits 3:0 decoded)
`define WWD_OFS_RESTART_CONTROL   4'h0
`define WWD_OFS_MODE_CONFIG_ONCE  4'h4
`define WWD_OFS_FAULT_STATUS      4'h8

// restart_control fields
`define WWD_WRITE_KEY_VALUE       8'ha5
`define WWD_KEY_MSB               31
`define WWD_KEY_LSB               24
`define WWD_RESTART_BIT           0

// mode_config_once fields
`define WWD_RELOAD_MSB            11
`define WWD_RELOAD_LSB            0
`define WWD_FAULT_IRQ_EN_BIT      12
`define WWD_RESET_EN_BIT          13
`define WWD_PROC_ONLY_BIT         14
`define WWD_DISABLE_BIT           15
`define WWD_DELTA_MSB             27
`define WWD_DELTA_LSB             16
`define WWD_DEBUG_HALT_BIT        28
`define WWD_IDLE_HALT_BIT         29
`define WWD_MODE_RESET            32'h3fff2fff
`define WWD_MODE_MASK             32'h3fffffff

// fault_status fields
`define WWD_UNDERFLOW_BIT         0
`define WWD_WINDOW_ERROR_BIT      1

// timing: slow clock divided by this for one counter tick
`define WWD_PRESCALE_DIV          128
`define WWD_COUNTER_WIDTH         12

`endif

//--- design/wwd_tick_div.v
// divider making one-cycle tick enables from the slow clock enable
`timescale 1ns/10ps
`default_nettype none
`include "wwd_defs.vh"

module wwd_tick_div #(
    parameter DIVIDE = `WWD_PRESCALE_DIV,
    parameter WIDTH  = 7
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // control
    input  wire             clear_i,
    input  wire             enable_i,
    input  wire             step_i,
    // result
    output reg              tick_o
);

    reg [WIDTH-1:0] count;

    // divide step pulses; clear restarts a full period
    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            count  <= {WIDTH{1'b0}};
            tick_o <= 1'b0;
        end else if (enable_i && step_i) begin
            if (count == DIVIDE[WIDTH-1:0] - 1'b1) begin
                count  <= {WIDTH{1'b0}};
                tick_o <= 1'b1;
            end else begin
                count  <= count + 1'b1;
                tick_o <= 1'b0;
            end
        end else begin
            tick_o <= 1'b0;
        end
    end

endmodule // wwd_tick_div
`default_nettype wire

//--- design/wwd_slow_tick.v
// divider making the slow clock enable pulse from the system clock
`timescale 1ns/10ps
`default_nettype none

module wwd_slow_tick #(
    parameter DIVIDE = 1526,
    parameter WIDTH  = 11
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // result
    output reg              tick_o
);

    reg [WIDTH-1:0] count;

    // free-running; approximates a 32.768 kHz slow clock at 50 MHz
    always @(posedge clk_i) begin
        if (rst_i) begin
            count  <= {WIDTH{1'b0}};
            tick_o <= 1'b0;
        end else if (count == DIVIDE[WIDTH-1:0] - 1'b1) begin
            count  <= {WIDTH{1'b0}};
            tick_o <= 1'b1;
        end else begin
            count  <= count + 1'b1;
            tick_o <= 1'b0;
        end
    end

endmodule // wwd_slow_tick
`default_nettype wire

//--- dv/wwd_top_asserts.sv
// checker on the watchdog top ports
`timescale 1ns/10ps
`default_nettype none
module wwd_top_chk #(
    parameter SLOW_DIVIDE = 1526,
    parameter SLOW_WIDTH  = 11
) (
    // clock and reset
    input wire logic        MCLK_I,
    input wire logic        SYS_RST_I,
    // wishbone
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [3:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // state, faults, count
    input wire logic        DEBUG_STATE_I,
    input wire logic        IDLE_STATE_I,
    input wire logic        FAULT_IRQ_O,
    input wire logic        WDT_FAULT_O,
    input wire logic        PROC_ONLY_RESET_O,
    input wire logic [11:0] COUNT_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);
    // taken requests and the reads they start
    wire take  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire rd_st = take & ~WB_WE_I & (WB_ADR_I == 4'h8);
    wire rd_cr = take & ~WB_WE_I & (WB_ADR_I == 4'h0);
    // last count; a wrap 000 to fff is a reload, not a step
    logic [11:0] prev;
    always @(posedge MCLK_I) prev <= COUNT_O;
    wire dec = (COUNT_O == prev - 12'h001) && (prev != 12'h000);
    sequence s_dec; dec; endsequence
    sequence s_quiet; !dec [*8]; endsequence
    property p_ack_next; take |=> WB_ACK_O; endproperty
    property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    property p_ack_cause; $rose(WB_ACK_O) |-> $past(WB_CYC_I & WB_STB_I); endproperty
    property p_fault_hold; WDT_FAULT_O && !rd_st |=> WDT_FAULT_O; endproperty
    property p_st_rd; rd_st |=> WB_ACK_O && (WB_DAT_O[31:2] == 30'h0); endproperty
    property p_cr_rd; rd_cr |=> WB_DAT_O == 32'h0; endproperty
    property p_rst_val; $fell(SYS_RST_I) |-> COUNT_O == 12'hfff && !WDT_FAULT_O && !FAULT_IRQ_O; endproperty
    property p_dec_gap; s_dec |=> s_quiet; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped early");
    a_st_rd: assert property (p_st_rd) else $error("status read bad");
    a_cr_rd: assert property (p_cr_rd) else $error("control read not zero");
    a_rst_val: assert property (p_rst_val) else $error("bad values after reset");
    a_dec_gap: assert property (p_dec_gap) else $error("count stepped too soon");
endmodule // wwd_top_chk
bind wwd_top wwd_top_chk #(.SLOW_DIVIDE(SLOW_DIVIDE), .SLOW_WIDTH(SLOW_WIDTH)) u_chk (.*);
`default_nettype wire

//--- dv/wwd_rstc_model.sv
// reset controller model feeding the watchdog reset
`timescale 1ns/10ps
`default_nettype none
module wwd_rstc_model (
    // clock
    input  wire logic clk_i,
    // reset sources
    input  wire logic por_i,
    input  wire logic fault_i,
    input  wire logic rst_en_i,
    // reset out
    output var  logic rst_o
);
    // registered so a fault edge cannot glitch the reset
    always @(posedge clk_i) begin
        rst_o <= por_i | (fault_i & rst_en_i);
    end
endmodule // wwd_rstc_model
`default_nettype wire

//--- dv/windowed_watchdog_timer_tb.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_timer_tb;
    // clock, reset, bus and state
    logic        clk = 1'b0;
    logic        por = 1'b1;
    logic        rst;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wd = 32'h0;
    logic        dbg = 1'b0;
    logic        idl = 1'b0;
    logic [31:0] q;
    logic [11:0] held;
    wire  [31:0] rd;
    wire         ack, irq, flt, pro;
    wire  [11:0] cnt;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          n;
    // reads right after reset: address and value
    logic [3:0]  ra [4] = '{4'h0, 4'h4, 4'h8, 4'hc};
    logic [31:0] re [4] = '{32'h0, 32'h3fff2fff, 32'h0, 32'h0};
    always #10 clk = ~clk;
    // reset enable stays off, so faults never loop back into reset
    wwd_rstc_model u_rstc (.clk_i(clk), .por_i(por), .fault_i(flt), .rst_en_i(1'b0), .rst_o(rst));
    wwd_top #(.SLOW_DIVIDE(2), .SLOW_WIDTH(2)) dut (.MCLK_I(clk), .SYS_RST_I(rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .DEBUG_STATE_I(dbg),
        .IDLE_STATE_I(idl), .FAULT_IRQ_O(irq), .WDT_FAULT_O(flt),
        .PROC_ONLY_RESET_O(pro), .COUNT_O(cnt));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // classic cycle: hold until ack sampled, then release
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rst_run();
        por <= 1'b1;
        repeat (16) @(posedge clk);
        por <= 1'b0;
        @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        rst_run();
        chk("count", 32'hfff, {20'h0, cnt});
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, ra[i], 32'h0);
            chk("row", re[i], q);
        end
        $display("test reset done");
        wb(1'b1, 4'h4, 32'h10021005);
        repeat (3) @(posedge clk);
        chk("reload", 32'h5, {20'h0, cnt});
        wb(1'b1, 4'h4, 32'h00000fff);
        wb(1'b0, 4'h4, 32'h0);
        chk("mode", 32'h10021005, q);
        chk("proc_only", 32'h0, {31'h0, pro});
        $display("test mode done");
        wb(1'b1, 4'h0, 32'h5a000001);
        wb(1'b0, 4'h8, 32'h0);
        chk("badkey", 32'h0, q);
        wb(1'b1, 4'h0, 32'ha5000001);
        @(posedge clk);
        chk("early", 32'h3, {30'h0, irq, flt});
        wb(1'b0, 4'h8, 32'h0);
        chk("status", 32'h2, q);
        @(posedge clk);
        chk("cleared", 32'h0, {30'h0, irq, flt});
        $display("test window done");
        dbg <= 1'b1;
        // let a tick in flight settle into the observed count
        repeat (3) @(posedge clk);
        held = cnt;
        repeat (600) @(posedge clk);
        chk("halt", {20'h0, held}, {20'h0, cnt});
        dbg <= 1'b0;
        idl <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("unf", 32'h2, {30'h0, irq, flt});
        repeat (3) @(posedge clk);
        chk("again", 32'h5, {20'h0, cnt});
        wb(1'b0, 4'h8, 32'h0);
        chk("status", 32'h1, q);
        $display("test underflow done");
        rst_run();
        wb(1'b0, 4'h4, 32'h0);
        chk("mode", 32'h3fff2fff, q);
        $display("test rereset done");
        conclude();
    end
    // hang guard, well past the longest wait above
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule // windowed_watchdog_timer_tb
`default_nettype wire
